// ==== hw/cml_lock.sv ====
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module cml_lock
(
   // ahb-lite slave
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // fetch path
   input  wire logic        ea_pin,
   input  wire logic        tbl_req,
   input  wire logic        tbl_from_ext,
   input  wire logic [15:0] tbl_addr,
   output logic      [7:0]  tbl_data,
   output logic             tbl_valid,
   output logic             tbl_blocked,
   output logic             ea_eff
);
   import cml_pkg::*;

   // image size is fixed at 8k; the larger layouts only move the code top
   localparam int          CML_IMAGE_KB = 8;
   localparam logic [15:0] CML_CODE_TOP = (CML_IMAGE_KB == 32) ? CML_CODE_LAST32 :
                                          (CML_IMAGE_KB == 16) ? CML_CODE_LAST16 :
                                          CML_CODE_LAST;

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [7:0] code_mem [0:(1<<CML_MEM_AW)-1];
   logic [7:0] key_mem  [0:CML_KEY_BYTES-1];
   logic [CML_KEY_BYTES-1:0] key_prog;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   cml_state_type state, next_state;
   logic [11:0] a_addr, next_a_addr;
   logic [7:0]  sec, next_sec;
   logic        refused, next_refused;
   logic        ea_hold, next_ea_hold;
   logic        ea_caught, next_ea_caught;
   logic        vdone, next_vdone;
   logic [15:0] paddr, next_paddr;
   logic [15:0] vaddr, next_vaddr;
   logic [7:0]  vdata, next_vdata;
   logic [31:0] rdata, next_rdata;
   logic        ready_q, next_ready_q;
   logic [7:0]  tdata, next_tdata;
   logic        tvalid, next_tvalid;
   logic        tblk, next_tblk;
   logic        eaf, next_eaf;

   logic        lock1, lock2, enc_on;
   logic [7:0]  enc_byte;
   logic [7:0]  vkey;
   logic        wr_code, wr_key;

   // 0 in the lock byte enables protection
   assign lock1  = ~sec[CML_SEC_LOCK1];
   assign lock2  = ~sec[CML_SEC_LOCK2];
   assign enc_on = |key_prog;
   // unprogrammed key bytes read all ones
   assign vkey   = key_prog[vaddr[CML_KEY_AW-1:0]] ?
                   key_mem[vaddr[CML_KEY_AW-1:0]] : CML_BYTE_BLANK;

   cml_scramble u_scr
   (
      .code_byte (code_mem[vaddr[CML_MEM_AW-1:0]]),
      .key_byte  (vkey),
      .out_byte  (enc_byte)
   );

   // ---------------------------------------------------------------
   // bus and lock control
   // ---------------------------------------------------------------
   always_comb
   begin
      next_state     = CML_IDLE;
      next_a_addr    = a_addr;
      next_sec       = sec;
      next_refused   = refused;
      next_ea_hold   = ea_hold;
      next_ea_caught = 1'b1;
      next_vdone     = vdone;
      next_paddr     = paddr;
      next_vaddr     = vaddr;
      next_vdata     = vdata;
      next_rdata     = rdata;
      next_ready_q   = 1'b1;
      wr_code        = 1'b0;
      wr_key         = 1'b0;
      // pin is caught once, on the first edge after reset release
      if (!ea_caught)
         next_ea_hold = ea_pin;
      if (hsel && hready && htrans == CML_HTRANS_NONSEQ)
      begin
         next_a_addr  = haddr[11:0];
         next_state   = hwrite ? CML_WRITE : CML_READ;
         next_ready_q = hwrite;
      end
      case (state)
         CML_WRITE:
         begin
            if (a_addr == CML_ADDR_CTRL)
            begin
               if (hwdata[CML_CTRL_SETLK1])
                  next_sec[CML_SEC_LOCK1] = 1'b0;
               if (hwdata[CML_CTRL_SETLK2] && lock1)
                  next_sec[CML_SEC_LOCK2] = 1'b0;
               if (hwdata[CML_CTRL_PROG])
               begin
                  if (lock1)
                     next_refused = 1'b1;
                  else
                     wr_code = paddr <= CML_CODE_TOP;
               end
               if (hwdata[CML_CTRL_VERIFY])
               begin
                  next_vdone = 1'b1;
                  if (lock2)
                     next_vdata = CML_BYTE_BLANK;
                  else if (enc_on)
                     next_vdata = enc_byte;
                  else
                     next_vdata = code_mem[vaddr[CML_MEM_AW-1:0]];
               end
            end
            else if (a_addr == CML_ADDR_STATUS)
            begin
               if (hwdata[CML_ST_REFUSED])
                  next_refused = 1'b0;
               if (hwdata[CML_ST_VDONE])
                  next_vdone = 1'b0;
            end
            else if (a_addr == CML_ADDR_PADDR)
               next_paddr = hwdata[15:0];
            else if (a_addr == CML_ADDR_VADDR)
               next_vaddr = hwdata[15:0];
            else if (a_addr >= CML_ADDR_KEY && a_addr <= CML_ADDR_KEYEND)
            begin
               if (lock1)
                  next_refused = 1'b1;
               else
                  wr_key = 1'b1;
            end
         end
         CML_READ:
         begin
            next_rdata = 32'h0000_0000;
            if (a_addr == CML_ADDR_STATUS)
               next_rdata = {26'h000_0000, vdone, enc_on, ea_hold,
                             refused, lock2, lock1};
            else if (a_addr == CML_ADDR_PADDR)
               next_rdata = {16'h0000, paddr};
            else if (a_addr == CML_ADDR_VADDR)
               next_rdata = {16'h0000, vaddr};
            else if (a_addr == CML_ADDR_VDATA)
               next_rdata = {24'h00_0000, vdata};
            else if (a_addr >= CML_ADDR_KEY && a_addr <= CML_ADDR_KEYEND)
               next_rdata = {24'h00_0000, lock2 ? CML_BYTE_BLANK :
                  (key_prog[a_addr[CML_KEY_AW+1:2]] ? key_mem[a_addr[CML_KEY_AW+1:2]]
                   : CML_BYTE_BLANK)};
         end
         default:
         begin
         end
      endcase
   end

   // ---------------------------------------------------------------
   // fetch path
   // ---------------------------------------------------------------
   always_comb
   begin
      next_tvalid = tbl_req;
      next_tblk   = 1'b0;
      next_tdata  = tdata;
      next_eaf    = lock1 ? ea_hold : ea_pin;
      if (tbl_req)
      begin
         if (lock1 && tbl_from_ext)
         begin
            next_tblk  = 1'b1;
            next_tdata = CML_BYTE_BLANK;
         end
         else
            next_tdata = code_mem[tbl_addr[CML_MEM_AW-1:0]];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state     <= CML_IDLE;
         a_addr    <= 12'h000;
         sec       <= CML_SEC_RESET;
         refused   <= 1'b0;
         ea_hold   <= 1'b0;
         ea_caught <= 1'b0;
         vdone     <= 1'b0;
         paddr     <= 16'h0000;
         vaddr     <= 16'h0000;
         vdata     <= 8'h00;
         rdata     <= 32'h0000_0000;
         ready_q   <= 1'b1;
         tdata     <= 8'h00;
         tvalid    <= 1'b0;
         tblk      <= 1'b0;
         eaf       <= 1'b0;
         key_prog  <= '0;
      end
      else
      begin
         state     <= next_state;
         a_addr    <= next_a_addr;
         sec       <= next_sec;
         refused   <= next_refused;
         ea_hold   <= next_ea_hold;
         ea_caught <= next_ea_caught;
         vdone     <= next_vdone;
         paddr     <= next_paddr;
         vaddr     <= next_vaddr;
         vdata     <= next_vdata;
         rdata     <= next_rdata;
         ready_q   <= next_ready_q;
         tdata     <= next_tdata;
         tvalid    <= next_tvalid;
         tblk      <= next_tblk;
         eaf       <= next_eaf;
         if (wr_key)
            key_prog[a_addr[CML_KEY_AW+1:2]] <= 1'b1;
      end
   end

   // memories carry no reset
   always_ff @(posedge hclk)
   begin
      if (wr_code)
         code_mem[paddr[CML_MEM_AW-1:0]] <= hwdata[15:8];
      if (wr_key)
         key_mem[a_addr[CML_KEY_AW+1:2]] <= hwdata[7:0];
   end

   assign hrdata    = rdata;
   assign hreadyout = ready_q;
   assign hresp     = 1'b0;
   assign tbl_data  = tdata;
   assign tbl_valid = tvalid;
   assign tbl_blocked = tblk;
   assign ea_eff    = eaf;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   tbl_block_a : assert property (@(posedge hclk) disable iff (!hresetn)
      tbl_req && tbl_from_ext && lock1 |=> tbl_blocked && tbl_data == CML_BYTE_BLANK)
      else $error("external table read not blocked");
   ea_hold_a : assert property (@(posedge hclk) disable iff (!hresetn)
      lock1 && $past(lock1) |=> ea_eff == $past(ea_hold))
      else $error("latched access select not used");
   prog_refuse_a : assert property (@(posedge hclk) disable iff (!hresetn)
      state == CML_WRITE && a_addr == CML_ADDR_CTRL && hwdata[CML_CTRL_PROG] && lock1
      |-> !wr_code ##1 refused)
      else $error("program under lock not refused");
   verify_off_a : assert property (@(posedge hclk) disable iff (!hresetn)
      state == CML_WRITE && a_addr == CML_ADDR_CTRL && hwdata[CML_CTRL_VERIFY] && lock2
      |=> vdata == CML_BYTE_BLANK)
      else $error("verify returned data under both locks");
   key_blank_a : assert property (@(posedge hclk) disable iff (!hresetn)
      state == CML_READ && a_addr >= CML_ADDR_KEY && a_addr <= CML_ADDR_KEYEND
      && !key_prog[a_addr[CML_KEY_AW+1:2]] |=> hrdata == {24'h00_0000, CML_BYTE_BLANK})
      else $error("unprogrammed key byte not all ones");
   plain_verify_a : assert property (@(posedge hclk) disable iff (!hresetn)
      state == CML_WRITE && a_addr == CML_ADDR_CTRL && hwdata[CML_CTRL_VERIFY]
      && !lock2 && !enc_on |=> vdata == $past(code_mem[vaddr[CML_MEM_AW-1:0]]))
      else $error("plain verify wrong");
   read_wait_a : assert property (@(posedge hclk) disable iff (!hresetn)
      state == CML_READ |-> !hreadyout ##1 hreadyout)
      else $error("read answer timing wrong");
   lock_order_a : assert property (@(posedge hclk) disable iff (!hresetn)
      lock2 |-> lock1)
      else $error("second lock without first");

endmodule : cml_lock

// ==== hw/cml_pkg.sv ====
package cml_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] CML_ADDR_CTRL   = 12'h000;
   localparam logic [11:0] CML_ADDR_STATUS = 12'h004;
   localparam logic [11:0] CML_ADDR_PADDR  = 12'h008;
   localparam logic [11:0] CML_ADDR_PDATA  = 12'h00C;
   localparam logic [11:0] CML_ADDR_VADDR  = 12'h010;
   localparam logic [11:0] CML_ADDR_VDATA  = 12'h014;
   localparam logic [11:0] CML_ADDR_KEY    = 12'h100;
   localparam logic [11:0] CML_ADDR_KEYEND = 12'h1FC;

   // ---------------------------------------------------------------
   // memory layout per variant
   // ---------------------------------------------------------------
   localparam int          CML_MEM_AW      = 13;
   localparam logic [15:0] CML_CODE_LAST   = 16'h1FFF;
   localparam logic [15:0] CML_KEY_FIRST   = 16'h2000;
   localparam logic [15:0] CML_KEY_LAST    = 16'h201F;
   localparam logic [15:0] CML_SEC_ADDR    = 16'h2020;
   localparam logic [15:0] CML_CODE_LAST16 = 16'h3FFF;
   localparam logic [15:0] CML_SEC_ADDR16  = 16'h4020;
   localparam logic [15:0] CML_CODE_LAST32 = 16'h7FFF;
   localparam logic [15:0] CML_SEC_ADDR32  = 16'h8020;
   localparam int          CML_KEY_BYTES   = 64;
   localparam int          CML_KEY_AW      = 6;
   localparam logic [7:0]  CML_BYTE_BLANK  = 8'hFF;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CML_SEC_LOCK1    = 0;
   localparam int CML_SEC_LOCK2    = 1;
   localparam int CML_CTRL_PROG    = 0;
   localparam int CML_CTRL_VERIFY  = 1;
   localparam int CML_CTRL_SETLK1  = 2;
   localparam int CML_CTRL_SETLK2  = 3;
   localparam int CML_ST_LOCK1     = 0;
   localparam int CML_ST_LOCK2     = 1;
   localparam int CML_ST_REFUSED   = 2;
   localparam int CML_ST_EAHOLD    = 3;
   localparam int CML_ST_ENCRYPT   = 4;
   localparam int CML_ST_VDONE     = 5;

   localparam logic [1:0] CML_HTRANS_NONSEQ = 2'b10;
   localparam logic [7:0] CML_SEC_RESET     = 8'hFF;

   typedef enum logic [2:0]
   {
      CML_IDLE  = 3'b001,
      CML_WRITE = 3'b010,
      CML_READ  = 3'b100
   } cml_state_type;

endpackage : cml_pkg

// ==== hw/cml_scramble.sv ====
`timescale 1ns/1ns
module cml_scramble
(
   // code byte and its key
   input  wire logic [7:0] code_byte,
   input  wire logic [7:0] key_byte,
   // result
   output logic      [7:0] out_byte
);
   import cml_pkg::*;

   // key of all ones passes code through unchanged
   always_comb
   begin
      if (key_byte == CML_BYTE_BLANK)
         out_byte = code_byte;
      else
         out_byte = code_byte ^ ~key_byte;
   end

endmodule : cml_scramble

// ==== sim/cml_fetch_model.sv ====
`timescale 1ns/1ns
// ---------------------------------------------
// processor table-read path
// ---------------------------------------------
module cml_fetch_model
(
   // clock and command from the bench
   input  wire logic        hclk,
   input  wire logic        start,
   input  wire logic        from_ext,
   input  wire logic [15:0] addr,
   // toward the lock block
   output logic             tbl_req,
   output logic             tbl_from_ext,
   output logic      [15:0] tbl_addr,
   input  wire logic [7:0]  tbl_data,
   input  wire logic        tbl_valid,
   input  wire logic        tbl_blocked,
   // captured answer
   output logic             got_valid,
   output logic      [7:0]  got_data,
   output logic             got_blocked
);
   initial
   begin
      tbl_req      = 1'h0;
      tbl_from_ext = 1'h0;
      tbl_addr     = 16'h0000;
      got_valid    = 1'h0;
   end
   // address is inverted once taken, so a late sample cannot pass
   always @(posedge hclk)
   begin
      tbl_req <= start;
      if (start)
      begin
         tbl_from_ext <= from_ext;
         tbl_addr     <= addr;
      end
      else if (tbl_req)
         tbl_addr <= ~tbl_addr;
      got_valid <= tbl_valid;
      if (tbl_valid)
      begin
         got_data    <= tbl_data;
         got_blocked <= tbl_blocked;
      end
   end
endmodule : cml_fetch_model

// ==== sim/code_memory_security_lock_test.sv ====
`timescale 1ns/1ns
module code_memory_security_lock_test;
   import cml_pkg::*;
   typedef struct {logic [15:0] a; logic [7:0] c;} cml_row_type;
   logic        hclk = 1'h0;
   logic        hresetn, hwrite, ea_pin, start, from_ext;
   logic [31:0] haddr, hwdata, rdv;
   logic [1:0]  htrans;
   logic [15:0] f_addr;
   logic [7:0]  v;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, tbl_req, tbl_from_ext, tbl_valid, tbl_blocked, ea_eff;
   wire  [15:0] tbl_addr;
   wire  [7:0]  tbl_data, got_data;
   wire         got_valid, got_blocked;
   int          miscompares = 0;
   int          n_compared = 0;
   cml_row_type rows [4] = '{'{16'h0000, 8'h5A}, '{CML_CODE_LAST, 8'hC3},
                             '{16'h0040, 8'h96}, '{16'h1234, 8'h00}};

   always #4 hclk = ~hclk;

   cml_lock DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ea_pin(ea_pin), .tbl_req(tbl_req), .tbl_from_ext(tbl_from_ext),
      .tbl_addr(tbl_addr), .tbl_data(tbl_data), .tbl_valid(tbl_valid),
      .tbl_blocked(tbl_blocked), .ea_eff(ea_eff));
   cml_fetch_model fetch_side (.hclk(hclk), .start(start), .from_ext(from_ext),
      .addr(f_addr), .tbl_req(tbl_req), .tbl_from_ext(tbl_from_ext),
      .tbl_addr(tbl_addr), .tbl_data(tbl_data), .tbl_valid(tbl_valid),
      .tbl_blocked(tbl_blocked), .got_valid(got_valid), .got_data(got_data),
      .got_blocked(got_blocked));

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task close_out;
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // a wait that runs out ends the run as a mismatch
   task wait_on(input int which);
      int n;
      n = 0;
      @(posedge hclk);
      while ((which == 0 ? hreadyout : got_valid) !== 1'h1)
      begin
         n++;
         if (n > 20)
         begin
            miscompares++;
            close_out;
         end
         @(posedge hclk);
      end
   endtask : wait_on

   task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      htrans <= CML_HTRANS_NONSEQ;
      haddr  <= {20'h0_0000, a};
      hwrite <= wr;
      wait_on(0);
      htrans <= 2'h0;
      hwdata <= wd;
      wait_on(0);
      rdv = hrdata;
   endtask : ahb

   task fetch(input logic ext, input logic [15:0] a);
      start    <= 1'h1;
      from_ext <= ext;
      f_addr   <= a;
      @(posedge hclk);
      start    <= 1'h0;
      wait_on(1);
   endtask : fetch

   task prog(input logic [15:0] a, input logic [7:0] c);
      ahb(1'h1, CML_ADDR_PADDR, {16'h0000, a});
      ahb(1'h1, CML_ADDR_CTRL, {16'h0000, c, 8'h01});
   endtask : prog

   task verify(input logic [15:0] a);
      int n;
      ahb(1'h1, CML_ADDR_VADDR, {16'h0000, a});
      ahb(1'h1, CML_ADDR_CTRL, 32'h0000_0002);
      n = 0;
      ahb(1'h0, CML_ADDR_STATUS, 32'h0000_0000);
      while (rdv[CML_ST_VDONE] !== 1'h1 && n < 8)
      begin
         n++;
         ahb(1'h0, CML_ADDR_STATUS, 32'h0000_0000);
      end
      chk(32'(rdv[CML_ST_VDONE]), 32'h0000_0001);
      ahb(1'h0, CML_ADDR_VDATA, 32'h0000_0000);
      v = rdv[7:0];
      ahb(1'h1, CML_ADDR_STATUS, 32'h0000_0020);
   endtask : verify

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial
   begin
      hresetn = 1'h0;
      hwrite  = 1'h0;
      haddr   = 32'h0000_0000;
      hwdata  = 32'h0000_0000;
      htrans  = 2'h0;
      ea_pin  = 1'h1;
      start   = 1'h0;
      from_ext = 1'h0;
      f_addr  = 16'h0000;
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      ea_pin  <= 1'h0;
      ahb(1'h0, CML_ADDR_STATUS, 32'h0000_0000);
      chk(rdv & 32'h0000_0037, 32'h0000_0000);
      ahb(1'h0, CML_ADDR_KEY, 32'h0000_0000);
      chk(rdv, 32'(CML_BYTE_BLANK));
      ahb(1'h0, CML_ADDR_KEYEND, 32'h0000_0000);
      chk(rdv, 32'(CML_BYTE_BLANK));
      ahb(1'h0, 12'h00C, 32'h0000_0000);
      chk(rdv, 32'h0000_0000);
      chk(32'(ea_eff), 32'h0000_0000);
      foreach (rows[i])
      begin
         prog(rows[i].a, rows[i].c);
         verify(rows[i].a);
         chk(32'(v), 32'(rows[i].c));
         fetch(1'h1, rows[i].a);
         chk({got_blocked, got_data}, {23'h00_0000, 1'h0, rows[i].c});
      end
      // a byte past the code top must not alias onto address zero
      prog(CML_KEY_FIRST, 8'h11);
      verify(16'h0000);
      chk(32'(v), 32'h0000_005A);
      ahb(1'h1, CML_ADDR_KEY, 32'h0000_000F);
      ahb(1'h0, CML_ADDR_STATUS, 32'h0000_0000);
      chk(32'(rdv[CML_ST_ENCRYPT]), 32'h0000_0001);
      verify(16'h0040);
      chk(32'(v), 32'h0000_0066);
      verify(16'h1234);
      chk(32'(v), 32'h0000_0000);
      ahb(1'h1, CML_ADDR_CTRL, 32'h0000_0008);
      ahb(1'h0, CML_ADDR_STATUS, 32'h0000_0000);
      chk(rdv & 32'h0000_0003, 32'h0000_0000);
      ahb(1'h1, CML_ADDR_CTRL, 32'h0000_0004);
      ahb(1'h0, CML_ADDR_STATUS, 32'h0000_0000);
      chk(rdv & 32'h0000_0007, 32'h0000_0001);
      chk(32'(ea_eff), 32'h0000_0001);
      prog(16'h0000, 8'hFF);
      ahb(1'h0, CML_ADDR_STATUS, 32'h0000_0000);
      chk(rdv & 32'h0000_0007, 32'h0000_0005);
      verify(16'h0000);
      chk(32'(v), 32'h0000_00AA);
      fetch(1'h1, CML_CODE_LAST);
      chk({got_blocked, got_data}, 32'h0000_01FF);
      fetch(1'h0, CML_CODE_LAST);
      chk({got_blocked, got_data}, 32'h0000_00C3);
      ahb(1'h1, CML_ADDR_CTRL, 32'h0000_0008);
      ahb(1'h0, CML_ADDR_STATUS, 32'h0000_0000);
      chk(rdv & 32'h0000_0003, 32'h0000_0003);
      verify(16'h1234);
      chk(32'(v), 32'h0000_00FF);
      fetch(1'h1, 16'h0000);
      chk({got_blocked, got_data}, 32'h0000_01FF);
      chk(32'(ea_eff), 32'h0000_0001);
      hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      ahb(1'h0, CML_ADDR_STATUS, 32'h0000_0000);
      chk(rdv & 32'h0000_0003, 32'h0000_0000);
      chk(32'(ea_eff), 32'h0000_0000);
      chk(32'(hresp), 32'h0000_0000);
      close_out;
   end
endmodule : code_memory_security_lock_test
